// *** srp_pkg.sv ***
//==========================================================================
// How it works
// - Writing a port number 0 to 7 to the home-position port select puts the home-position signal on that output port.
// - Writing a port number 0 to 7 to the brake-control port select puts the brake-release signal on that output port.
// - Writing a port number 0 to 7 to the motion port select puts the motion signal on that output port.
// - The port number written selects the output port of the same index, so 1 selects output_port_one.
// - Routing settings live only in volatile flip-flops and are never copied to a nonvolatile_store.
// - Power-on, a program start by command or pin, or an alarm clear by command or pin returns every setting to its default.
// - Writing 1 to a signal's polarity flip inverts the level driven on the port that signal is routed to.
// - Direct on/off writes to a port that carries a routed signal are ignored for that port.
// - A read-only status word shows motion at bit 1, home-position at bit 4 and brake at bit 5, 1 while active.
package srp_pkg;

  //========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_HOME_SEL   = 12'h000;
  localparam logic [11:0] OFS_BRAKE_SEL  = 12'h004;
  localparam logic [11:0] OFS_MOTION_SEL = 12'h008;
  localparam logic [11:0] OFS_FLIP       = 12'h00c;
  localparam logic [11:0] OFS_DIRECT     = 12'h010;
  localparam logic [11:0] OFS_STATUS     = 12'h014;
  localparam logic [11:0] OFS_CMD        = 12'h018;

  //========================================================================
  // Field positions
  localparam int SIG_HOME       = 0;
  localparam int SIG_BRAKE      = 1;
  localparam int SIG_MOTION     = 2;
  localparam int STAT_MOTION    = 1;
  localparam int STAT_HOME      = 4;
  localparam int STAT_BRAKE     = 5;
  localparam int CMD_RESTORE    = 0;
  localparam int CMD_ALARM_CLR  = 1;
  localparam int CMD_PROG_START = 2;
  localparam int PIN_START      = 0;
  localparam int PIN_ALARM_CLR  = 1;

  //========================================================================
  // Values after reset and after a defaults restore
  localparam logic [2:0] SEL_DEFAULT    = 3'h0;
  localparam logic [2:0] ASSIGN_DEFAULT = 3'h0;
  localparam logic [2:0] FLIP_DEFAULT   = 3'h0;
  localparam logic [7:0] DIRECT_DEFAULT = 8'h00;

  //========================================================================
  // Internal status signals travel together
  typedef struct packed {
    logic motion;
    logic brake_release_signal;
    logic home_pos;
  } srp_status_s;

endpackage : srp_pkg

// *** srp_pin_sync.sv ***
`timescale 1ns/1ps
//==========================================================================
// Pin synchroniser: three stages, a change counts once stages two and
// three agree, and a one-cycle pulse marks each accepted rise.
module srp_pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Raw pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Filtered level and rise pulse
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] rise;
  } srp_sync_s;

  srp_sync_s st_ff;
  srp_sync_s nxt_st;

  // Stage one feeds only stage two, so no logic sees a metastable value
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.s1     = pin_in;
    nxt_st.s2     = st_ff.s1;
    nxt_st.s3     = st_ff.s2;
    nxt_st.stable = (st_ff.s2 == st_ff.s3) ? st_ff.s3 : st_ff.stable;
    nxt_st.rise   = nxt_st.stable & ~st_ff.stable;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.stable;
  assign rise  = st_ff.rise;

endmodule : srp_pin_sync

// *** srp_router.sv ***
`timescale 1ns/1ps
//==========================================================================
// Status output port router: places home-position, brake and motion
// status onto any of eight general output ports, APB programmed.
module srp_router #(
  parameter int NPORT = 8
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Internal status signals, same clock
  input  wire srp_pkg::srp_status_s status_in,
  // Pins: program start and alarm clear inputs
  input  wire logic                program_start_input,
  input  wire logic                alarm_clear_input,
  // General output ports
  output logic      [NPORT-1:0]    gen_out
);

  //========================================================================
  // State
  typedef struct packed {
    logic [2:0][2:0]   sel;
    logic [2:0]        assigned;
    logic [2:0]        flip;
    logic [NPORT-1:0]  direct;
    logic [NPORT-1:0]  port;
    logic [31:0]       rdata;
    logic              err;
  } srp_state_s;

  srp_state_s       st_ff;
  srp_state_s       nxt_st;
  logic [1:0]       pin_rise;
  logic [2:0]       active;
  logic [NPORT-1:0] routed;
  logic             wr_acc;
  logic             rd_setup;
  logic             restore;
  logic [31:0]      status_word;
  logic             addr_ok;

  // One-hot of a port number; used for every routed signal
  function automatic logic [NPORT-1:0] port_onehot(input logic [2:0] num);
    logic [NPORT-1:0] oh;
    oh      = '0;
    oh[num] = 1'b1;
    return oh;
  endfunction : port_onehot

  //========================================================================
  // Pin inputs cross into the clock domain
  srp_pin_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({alarm_clear_input, program_start_input}),
    .level   (),
    .rise    (pin_rise)
  );

  //========================================================================
  // Bus decode; zero wait states keep the slave simple
  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok  = (paddr == srp_pkg::OFS_HOME_SEL) || (paddr == srp_pkg::OFS_BRAKE_SEL)
                 || (paddr == srp_pkg::OFS_MOTION_SEL) || (paddr == srp_pkg::OFS_FLIP)
                 || (paddr == srp_pkg::OFS_DIRECT) || (paddr == srp_pkg::OFS_STATUS)
                 || (paddr == srp_pkg::OFS_CMD);

  // Status vector indexed by signal number
  assign active = {status_in.motion, status_in.brake_release_signal, status_in.home_pos};

  // Read-only status word
  always_comb begin
    status_word                      = '0;
    status_word[srp_pkg::STAT_MOTION] = status_in.motion;
    status_word[srp_pkg::STAT_HOME]   = status_in.home_pos;
    status_word[srp_pkg::STAT_BRAKE]  = status_in.brake_release_signal;
  end

  // Any of the default-restoring events; a restore beats a same-cycle write
  assign restore = pin_rise[srp_pkg::PIN_START] || pin_rise[srp_pkg::PIN_ALARM_CLR]
                || (wr_acc && (paddr == srp_pkg::OFS_CMD)
                    && (pwdata[srp_pkg::CMD_RESTORE] || pwdata[srp_pkg::CMD_ALARM_CLR]
                        || pwdata[srp_pkg::CMD_PROG_START]));

  //========================================================================
  // Next state: settings, port levels and read data
  always_comb begin
    nxt_st = st_ff;
    routed = '0;
    // Settings are held in flops only; nothing here reaches a store
    if (wr_acc) begin
      case (paddr)
        srp_pkg::OFS_HOME_SEL: begin
          nxt_st.sel[srp_pkg::SIG_HOME]      = pwdata[2:0];
          nxt_st.assigned[srp_pkg::SIG_HOME] = 1'b1;
        end
        srp_pkg::OFS_BRAKE_SEL: begin
          nxt_st.sel[srp_pkg::SIG_BRAKE]      = pwdata[2:0];
          nxt_st.assigned[srp_pkg::SIG_BRAKE] = 1'b1;
        end
        srp_pkg::OFS_MOTION_SEL: begin
          nxt_st.sel[srp_pkg::SIG_MOTION]      = pwdata[2:0];
          nxt_st.assigned[srp_pkg::SIG_MOTION] = 1'b1;
        end
        srp_pkg::OFS_FLIP: begin
          // Order of select and flip writes is left to software
          nxt_st.flip = pwdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // Ports owned by a routed signal; later signals win a shared port
    for (int i = 0; i < 3; i++) begin
      if (st_ff.assigned[i]) begin
        routed = routed | port_onehot(st_ff.sel[i]);
      end
    end
    // Direct writes only land on ports nobody routes to
    if (wr_acc && (paddr == srp_pkg::OFS_DIRECT)) begin
      nxt_st.direct = (st_ff.direct & routed) | (pwdata[NPORT-1:0] & ~routed);
    end
    // Port levels
    nxt_st.port = st_ff.direct;
    for (int i = 0; i < 3; i++) begin
      if (st_ff.assigned[i]) begin
        nxt_st.port[st_ff.sel[i]] = active[i] ^ st_ff.flip[i];
      end
    end
    // Read data is captured in the setup phase; selects and flips read zero
    nxt_st.rdata = '0;
    nxt_st.err   = 1'b0;
    if (psel && !penable) begin
      nxt_st.err = !addr_ok;
    end else if (psel) begin
      nxt_st.err = st_ff.err;
    end
    if (rd_setup) begin
      if (paddr == srp_pkg::OFS_STATUS) begin
        nxt_st.rdata = status_word;
      end else if (paddr == srp_pkg::OFS_DIRECT) begin
        nxt_st.rdata[NPORT-1:0] = st_ff.port;
      end
    end else if (psel) begin
      nxt_st.rdata = st_ff.rdata;
    end
    if (restore) begin
      nxt_st.sel      = {3{srp_pkg::SEL_DEFAULT}};
      nxt_st.assigned = srp_pkg::ASSIGN_DEFAULT;
      nxt_st.flip     = srp_pkg::FLIP_DEFAULT;
      nxt_st.direct   = srp_pkg::DIRECT_DEFAULT;
    end
  end

  // State register; power-on defaults come from the reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.sel      <= {3{srp_pkg::SEL_DEFAULT}};
      st_ff.assigned <= srp_pkg::ASSIGN_DEFAULT;
      st_ff.flip     <= srp_pkg::FLIP_DEFAULT;
      st_ff.direct   <= srp_pkg::DIRECT_DEFAULT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign gen_out = st_ff.port;
  assign prdata  = st_ff.rdata;
  assign pslverr = psel && penable && st_ff.err;

  //========================================================================
  // Checks
  logic home_owns;
  logic brake_owns;
  logic motion_owns;
  assign motion_owns = st_ff.assigned[2];
  assign brake_owns  = st_ff.assigned[1] && !(st_ff.assigned[2] && st_ff.sel[2] == st_ff.sel[1]);
  assign home_owns   = st_ff.assigned[0] && !(st_ff.assigned[2] && st_ff.sel[2] == st_ff.sel[0])
                    && !(st_ff.assigned[1] && st_ff.sel[1] == st_ff.sel[0]);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_home_route: assert property (
    home_owns |=> gen_out[$past(st_ff.sel[0])] == $past(active[0] ^ st_ff.flip[0]))
    else $error("home status not on its selected port");
  chk_brake_route: assert property (
    brake_owns |=> gen_out[$past(st_ff.sel[1])] == $past(active[1] ^ st_ff.flip[1]))
    else $error("brake status not on its selected port");
  chk_motion_route: assert property (
    motion_owns |=> gen_out[$past(st_ff.sel[2])] == $past(active[2] ^ st_ff.flip[2]))
    else $error("motion status not on its selected port");
  chk_sel_index: assert property (
    (wr_acc && paddr == srp_pkg::OFS_HOME_SEL && !restore) |=> ##1
      gen_out[$past(pwdata[2:0], 2)] == $past(active[0] ^ st_ff.flip[0])
      || !home_owns)
    else $error("home port number does not select same-index port");
  chk_defaults_restore: assert property (
    restore |=> (st_ff.assigned == 3'h0 && st_ff.flip == 3'h0 && st_ff.direct == 8'h00))
    else $error("settings not restored to defaults");
  chk_flip_apply: assert property (
    (wr_acc && paddr == srp_pkg::OFS_FLIP && !restore) |=> st_ff.flip == $past(pwdata[2:0]))
    else $error("polarity flip write not taken");
  chk_direct_ignored: assert property (
    (wr_acc && paddr == srp_pkg::OFS_DIRECT && !restore) |=>
      ((st_ff.direct & $past(routed)) == ($past(st_ff.direct) & $past(routed))))
    else $error("direct write changed a routed port");
  chk_status_word: assert property (
    (rd_setup && paddr == srp_pkg::OFS_STATUS) |=> prdata == $past(status_word))
    else $error("status word read mismatch");
  chk_wo_readback: assert property (
    (rd_setup && (paddr == srp_pkg::OFS_HOME_SEL || paddr == srp_pkg::OFS_FLIP))
      |=> prdata == 32'h0000_0000)
    else $error("write-only setting read back nonzero");

  cov_home_routed:  cover property (wr_acc && paddr == srp_pkg::OFS_HOME_SEL ##2 home_owns);
  cov_flip_set:     cover property (motion_owns && st_ff.flip[2]);
  cov_pin_restore:  cover property (pin_rise[srp_pkg::PIN_ALARM_CLR] && st_ff.assigned != 3'h0);
  cov_direct_block: cover property (wr_acc && paddr == srp_pkg::OFS_DIRECT && routed != '0);

endmodule : srp_router

// *** srp_port_sampler.sv ***
`timescale 1ns/1ps
//==========================================================================
// Far-side equipment: takes one sample of the general output ports a clock
module srp_port_sampler #(
  parameter int NPORT = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Ports on the wire and the last sample taken
  input  wire logic [NPORT-1:0] port_in,
  output logic      [NPORT-1:0] sampled_ff
);
  // Registered sample, so the bench never races the router's own update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sampled_ff <= '0;
    end else begin
      sampled_ff <= port_in;
    end
  end
endmodule : srp_port_sampler

// *** tb_status_output_port_router.sv ***
`timescale 1ns/1ps
//==========================================================================
// Bench for the status output port router
module tb_status_output_port_router;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic                 pready;
  logic                 pslverr;
  logic                 perr;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic [31:0]          rdata;
  srp_pkg::srp_status_s status_in;
  logic                 program_start_input;
  logic                 alarm_clear_input;
  logic [7:0]           gen_out;
  logic [7:0]           seen;
  int                   errors;
  int                   check_count;
  int                   s;
  int                   p;
  int                   k;

  // 20 MHz clock
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  srp_router #(.NPORT(8)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .status_in(status_in),
    .program_start_input(program_start_input),
    .alarm_clear_input(alarm_clear_input), .gen_out(gen_out)
  );

  srp_port_sampler #(.NPORT(8)) i_host (
    .pclk(pclk), .presetn(presetn), .port_in(gen_out), .sampled_ff(seen)
  );

  //========================================================================
  // Checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; an idle edge first keeps psel from being set twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata = prdata;
    perr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd

  // Three edges cover the registered output plus the far-side sample
  task automatic port_is(input logic [7:0] e);
    repeat (3) @(posedge pclk);
    chk({24'h0, seen}, {24'h0, e});
  endtask : port_is

  // Home, brake, motion onto ports 0, 1, 2, always before the flips
  task automatic route_three();
    wr(srp_pkg::OFS_HOME_SEL, 32'h0);
    wr(srp_pkg::OFS_BRAKE_SEL, 32'h1);
    wr(srp_pkg::OFS_MOTION_SEL, 32'h2);
    wr(srp_pkg::OFS_FLIP, 32'h5);
  endtask : route_three

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  //========================================================================
  // Watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    report_and_stop();
  end

  //========================================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    status_in = '0;
    program_start_input = 1'b0;
    alarm_clear_input = 1'b0;
    errors = 0;
    check_count = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    port_is(8'h00);
    rd(srp_pkg::OFS_HOME_SEL, 32'h0);
    rd(srp_pkg::OFS_FLIP, 32'h0);
    // Every combination of the three status signals in the status word
    for (k = 0; k < 8; k++) begin
      status_in <= srp_pkg::srp_status_s'(3'(k));
      @(posedge pclk);
      rd(srp_pkg::OFS_STATUS, {26'h0, k[1], k[0], 2'b00, k[2], 1'b0});
    end
    status_in <= '0;
    // Each signal onto each port; earlier routes stay, idle, on port 7
    for (s = 0; s < 3; s++) begin
      for (p = 0; p < 8; p++) begin
        wr(srp_pkg::OFS_HOME_SEL + 12'(4 * s), 32'(p));
        status_in <= srp_pkg::srp_status_s'(3'(1 << s));
        port_is(8'(1 << p));
        status_in <= '0;
        port_is(8'h00);
      end
    end
    rd(srp_pkg::OFS_MOTION_SEL, 32'h0);
    route_three();
    status_in <= srp_pkg::srp_status_s'(3'h3);
    port_is(8'h06);
    wr(srp_pkg::OFS_DIRECT, 32'hff);
    port_is(8'hfe);
    rd(srp_pkg::OFS_DIRECT, 32'hfe);
    wr(srp_pkg::OFS_FLIP, 32'h2);
    port_is(8'hf9);
    wr(srp_pkg::OFS_DIRECT, 32'h0);
    rd(12'h01c, 32'h0);
    chk({31'h0, perr}, 32'h1);
    // Each restore source: three command bits, then the two pins
    for (k = 0; k < 5; k++) begin
      route_three();
      port_is(8'h06);
      if (k < 3) begin
        wr(srp_pkg::OFS_CMD, 32'(1 << k));
      end else begin
        program_start_input <= (k == 3);
        alarm_clear_input   <= (k == 4);
        repeat (4) @(posedge pclk);
        program_start_input <= 1'b0;
        alarm_clear_input   <= 1'b0;
        repeat (8) @(posedge pclk);
      end
      port_is(8'h00);
    end
    report_and_stop();
  end
endmodule : tb_status_output_port_router
